// ### design/sdtc_ctrl.sv
// sdram command timing engine with host request port on the link clock
`timescale 1ns/100ps
module sdtc_ctrl import sdtc_pkg::*; #(
  parameter int POWERUP_CYCLES = POWERUP_CYC,
  parameter int CAS_LATENCY    = CAS_LATENCY_DEF,
  parameter int INIT_REFRESHES = INIT_REFRESH_DEF
) (
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  input  wire logic               link_clk,
  input  wire logic               host_valid,
  output logic                    host_ready,
  input  wire logic               host_write,
  input  wire logic [HADDR_W-1:0] host_addr,
  input  wire logic [DQ_W-1:0]    host_wdata,
  input  wire logic [DQM_W-1:0]   host_be,
  output logic                    host_rvalid,
  output logic [DQ_W-1:0]         host_rdata,
  input  wire logic               host_rready,
  output logic                    init_done,
  output logic                    sd_cke,
  output logic [NCS-1:0]          sd_cs_n,
  output logic                    sd_ras_n,
  output logic                    sd_cas_n,
  output logic                    sd_we_n,
  output logic [BA_W-1:0]         sd_ba,
  output logic [ROW_W-1:0]        sd_addr,
  output logic [DQM_W-1:0]        sd_dqm,
  output logic [DQ_W-1:0]         sd_dq_drive,
  output logic                    sd_dq_oe,
  input  wire logic [DQ_W-1:0]    sd_dq_sample
);
  localparam int RD_LAT = CAS_LATENCY + AC_CYC;

  typedef struct packed {
    sdtc_state_e          st;
    sdtc_state_e          ret;
    logic [15:0]          wait_cnt;
    logic [15:0]          ref_cnt;
    logic                 ref_due;
    logic [3:0]           init_refs;
    logic                 row_open;
    logic [CS_W-1:0]      o_cs;
    logic [BA_W-1:0]      o_ba;
    logic [ROW_W-1:0]     o_row;
    logic [15:0]          wr_cnt;
    logic [2:0]           rq_sync;
    logic                 rq_seen;
    logic                 have_req;
    logic                 r_we;
    logic [HADDR_W-1:0]   r_addr;
    logic [DQ_W-1:0]      r_wdata;
    logic [DQM_W-1:0]     r_be;
    logic                 ack_tgl;
    logic [7:0]           rd_pipe;
    logic                 cap_valid;
    logic [DQ_W-1:0]      cap_data;
    logic [2:0]           rt_sync;
    logic                 rt_tgl;
    logic [DQ_W-1:0]      rt_data;
    logic                 cke;
    logic [NCS-1:0]       cs_n;
    logic [2:0]           cmd;
    logic [BA_W-1:0]      ba;
    logic [ROW_W-1:0]     addr;
    logic [DQM_W-1:0]     dqm;
    logic [DQ_W-1:0]      dq_o;
    logic                 dq_oe;
    logic                 init_done;
  } sdtc_ref_s;

  typedef struct packed {
    logic                 ready;
    logic                 req_tgl;
    logic                 we;
    logic [HADDR_W-1:0]   addr;
    logic [DQ_W-1:0]      wdata;
    logic [DQM_W-1:0]     be;
    logic [2:0]           ak_sync;
    logic                 ak_seen;
    logic [2:0]           rt_sync;
    logic                 rt_seen;
    logic                 rvalid;
    logic [DQ_W-1:0]      rdata;
    logic                 rt_ack;
  } sdtc_link_s;

  localparam sdtc_ref_s REF_RST = '{st: ST_PWRUP, ret: ST_IDLE, wait_cnt: 16'(POWERUP_CYCLES),
                                    ref_cnt: REF_INT_CYC, cs_n: '1, cmd: CMD_NOP, dqm: '1,
                                    cke: 1'b1, default: '0};
  localparam sdtc_link_s LINK_RST = '{ready: 1'b1, default: '0};

  function automatic logic [NCS-1:0] cs_sel(input logic [CS_W-1:0] c);
    cs_sel = ~(NCS'(1) << c);
  endfunction

  sdtc_ref_s  q;
  sdtc_ref_s  n;
  sdtc_link_s lq;
  sdtc_link_s ln;

  sdtc_stream_if #(.W(DQ_W)) cap_if ();
  sdtc_stream_if #(.W(DQ_W)) ret_if ();

  sdtc_fifo #(.W(DQ_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .push  (cap_if),
    .pop   (ret_if)
  );

  assign cap_if.valid = q.cap_valid;
  assign cap_if.data  = q.cap_data;

  // ---------------- command engine, ref_clk domain ----------------
  always_comb begin
    logic take;
    logic tick;
    logic same_row;
    logic rd_block;
    logic pop_ok;
    take     = 1'b0;
    tick     = 1'b0;
    same_row = 1'b0;
    rd_block = 1'b0;
    pop_ok   = 1'b0;
    n        = q;
    n.cmd       = CMD_NOP;
    n.cs_n      = '1;
    n.dq_oe     = 1'b0;
    n.dqm       = '0;
    n.cap_valid = 1'b0;
    n.rd_pipe   = {q.rd_pipe[6:0], 1'b0};
    if (q.rd_pipe[RD_LAT-1]) begin
      n.cap_valid = 1'b1;
      n.cap_data  = sd_dq_sample;
    end
    if (q.wr_cnt != 16'h0000) begin
      n.wr_cnt = q.wr_cnt - 16'h0001;
    end
    // refresh interval timer, set wins over clear
    if (q.init_done) begin
      if (q.ref_cnt == 16'h0000) begin
        tick      = 1'b1;
        n.ref_cnt = REF_INT_CYC - 16'h0001;
        n.ref_due = 1'b1;
      end else begin
        n.ref_cnt = q.ref_cnt - 16'h0001;
      end
    end
    // request handshake from link side
    n.rq_sync = {q.rq_sync[1:0], lq.req_tgl};
    take = (q.rq_sync[1] == q.rq_sync[2]) && (q.rq_sync[2] != q.rq_seen) && !q.have_req;
    if (take) begin
      n.rq_seen  = q.rq_sync[2];
      n.have_req = 1'b1;
      n.r_we     = lq.we;
      n.r_addr   = lq.addr;
      n.r_wdata  = lq.wdata;
      n.r_be     = lq.be;
    end
    // return handshake toward link side
    n.rt_sync = {q.rt_sync[1:0], lq.rt_ack};
    pop_ok    = (q.rt_sync[1] == q.rt_sync[2]) && (q.rt_sync[2] == q.rt_tgl);
    ret_if.ready = pop_ok;
    if (pop_ok && ret_if.valid) begin
      n.rt_data = ret_if.data;
      n.rt_tgl  = ~q.rt_tgl;
    end
    same_row = q.row_open && (q.o_cs == q.r_addr[CS_LSB +: CS_W])
               && (q.o_ba == q.r_addr[BA_LSB +: BA_W]) && (q.o_row == q.r_addr[ROW_LSB +: ROW_W]);
    rd_block = !q.r_we && (!cap_if.ready || (q.rd_pipe != 8'h00) || q.cap_valid);
    case (q.st)
      ST_PWRUP: begin
        if (q.wait_cnt == 16'h0000) begin
          n.st = ST_INIT_PRE;
        end else begin
          n.wait_cnt = q.wait_cnt - 16'h0001;
        end
      end
      ST_INIT_PRE: begin
        n.cmd           = CMD_PRE;
        n.cs_n          = '0;
        n.addr          = '0;
        n.addr[A10_BIT] = 1'b1;
        n.wait_cnt      = RP_CYC - 16'h0001;
        n.ret           = ST_INIT_REF;
        n.st            = ST_WAIT;
      end
      ST_INIT_REF: begin
        n.cmd       = CMD_REF;
        n.cs_n      = '0;
        n.init_refs = q.init_refs + 4'h1;
        n.wait_cnt  = RFC_CYC - 16'h0001;
        n.ret       = (q.init_refs + 4'h1 >= 4'(INIT_REFRESHES)) ? ST_INIT_MRS : ST_INIT_REF;
        n.st        = ST_WAIT;
      end
      ST_INIT_MRS: begin
        n.cmd       = CMD_MRS;
        n.cs_n      = '0;
        n.ba        = '0;
        n.addr      = ROW_W'({3'(CAS_LATENCY), 4'h0});
        n.wait_cnt  = MRD_CYC - 16'h0001;
        n.ret       = ST_IDLE;
        n.st        = ST_WAIT;
        n.init_done = 1'b1;
      end
      ST_IDLE: begin
        if (q.ref_due || (q.row_open && !(q.have_req && same_row))) begin
          if (q.row_open) begin
            if (q.wr_cnt == 16'h0000) begin
              n.cmd           = CMD_PRE;
              n.cs_n          = cs_sel(q.o_cs);
              n.ba            = q.o_ba;
              n.addr          = '0;
              n.row_open      = 1'b0;
              n.wait_cnt      = RP_CYC - 16'h0001;
              n.ret           = ST_IDLE;
              n.st            = ST_WAIT;
            end
          end else begin
            n.cmd      = CMD_REF;
            n.cs_n     = '0;
            n.ref_due  = tick;
            n.wait_cnt = RFC_CYC - 16'h0001;
            n.ret      = ST_IDLE;
            n.st       = ST_WAIT;
          end
        end else if (q.have_req) begin
          if (!q.row_open) begin
            n.cmd      = CMD_ACT;
            n.cs_n     = cs_sel(q.r_addr[CS_LSB +: CS_W]);
            n.ba       = q.r_addr[BA_LSB +: BA_W];
            n.addr     = q.r_addr[ROW_LSB +: ROW_W];
            n.o_cs     = q.r_addr[CS_LSB +: CS_W];
            n.o_ba     = q.r_addr[BA_LSB +: BA_W];
            n.o_row    = q.r_addr[ROW_LSB +: ROW_W];
            n.row_open = 1'b1;
            n.wait_cnt = RCD_CYC - 16'h0001;
            n.ret      = ST_IDLE;
            n.st       = ST_WAIT;
          end else if (!rd_block) begin
            n.cs_n     = cs_sel(q.o_cs);
            n.ba       = q.o_ba;
            n.addr     = ROW_W'(q.r_addr[COL_W-1:0]);
            n.have_req = 1'b0;
            n.ack_tgl  = ~q.ack_tgl;
            if (q.r_we) begin
              n.cmd    = CMD_WR;
              n.dq_o   = q.r_wdata;
              n.dq_oe  = 1'b1;
              n.dqm    = ~q.r_be;
              n.wr_cnt = WR_CYC - 16'h0001;
            end else begin
              n.cmd        = CMD_RD;
              n.rd_pipe[0] = 1'b1;
            end
          end
        end
      end
      ST_WAIT: begin
        if (q.wait_cnt <= 16'h0001) begin
          n.st = q.ret;
        end else begin
          n.wait_cnt = q.wait_cnt - 16'h0001;
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= REF_RST;
    end else begin
      q <= n;
    end
  end

  // ---------------- host port, link_clk domain ----------------
  always_comb begin
    ln         = lq;
    ln.ak_sync = {lq.ak_sync[1:0], q.ack_tgl};
    ln.rt_sync = {lq.rt_sync[1:0], q.rt_tgl};
    if (host_valid && lq.ready) begin
      ln.ready   = 1'b0;
      ln.req_tgl = ~lq.req_tgl;
      ln.we      = host_write;
      ln.addr    = host_addr;
      ln.wdata   = host_wdata;
      ln.be      = host_be;
    end else if ((lq.ak_sync[1] == lq.ak_sync[2]) && (lq.ak_sync[2] != lq.ak_seen)) begin
      ln.ak_seen = lq.ak_sync[2];
      ln.ready   = 1'b1;
    end
    if (lq.rvalid && host_rready) begin
      ln.rvalid = 1'b0;
      ln.rt_ack = lq.rt_seen;
    end else if (!lq.rvalid && (lq.rt_sync[1] == lq.rt_sync[2]) && (lq.rt_sync[2] != lq.rt_seen)) begin
      ln.rt_seen = lq.rt_sync[2];
      ln.rdata   = q.rt_data;
      ln.rvalid  = 1'b1;
    end
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      lq <= LINK_RST;
    end else begin
      lq <= ln;
    end
  end

  // all chips share address, command and data lanes, each chip has its own select
  assign sd_cke      = q.cke;
  assign sd_cs_n     = q.cs_n;
  assign sd_ras_n    = q.cmd[2];
  assign sd_cas_n    = q.cmd[1];
  assign sd_we_n     = q.cmd[0];
  assign sd_ba       = q.ba;
  assign sd_addr     = q.addr;
  assign sd_dqm      = q.dqm;
  assign sd_dq_drive = q.dq_o;
  assign sd_dq_oe    = q.dq_oe;
  assign init_done   = q.init_done;
  assign host_ready  = lq.ready;
  assign host_rvalid = lq.rvalid;
  assign host_rdata  = lq.rdata;

  // ---------------- checks ----------------
  localparam int          AST_RD_LAT  = RD_LAT;
  localparam logic [15:0] AST_REF_MAX = REF_INT_CYC + RFC_CYC + RP_CYC + WR_CYC + RCD_CYC + 16'h0008;

  logic        cmd_any;
  logic [15:0] ast_since_q;
  logic [15:0] ast_since_wr_q;
  logic [15:0] ast_since_ref_q;
  logic [2:0]  ast_last_q;
  logic        ast_first_q;

  assign cmd_any = ~&q.cs_n;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ast_since_q     <= '0;
      ast_since_wr_q  <= '0;
      ast_since_ref_q <= '0;
      ast_last_q      <= CMD_NOP;
      ast_first_q     <= 1'b1;
    end else begin
      ast_since_q     <= cmd_any ? 16'h0001 : ((ast_since_q == 16'hFFFF) ? ast_since_q : ast_since_q + 16'h0001);
      ast_since_wr_q  <= (cmd_any && q.cmd == CMD_WR) ? 16'h0001
                         : ((ast_since_wr_q == 16'hFFFF) ? ast_since_wr_q : ast_since_wr_q + 16'h0001);
      ast_since_ref_q <= (cmd_any && q.cmd == CMD_REF) ? 16'h0001
                         : ((ast_since_ref_q == 16'hFFFF) ? ast_since_ref_q : ast_since_ref_q + 16'h0001);
      if (cmd_any) begin
        ast_last_q  <= q.cmd;
        ast_first_q <= 1'b0;
      end
    end
  end

  sequence s_issue(logic [2:0] c);
    cmd_any && (q.cmd == c);
  endsequence

  sequence s_access;
    cmd_any && ((q.cmd == CMD_RD) || (q.cmd == CMD_WR));
  endsequence

  AST_CAS_CAPTURE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_issue(CMD_RD) |-> ##AST_RD_LAT q.cap_valid) else $error("read data not captured at latency");
  AST_INIT_REFS: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_issue(CMD_MRS) |-> (q.init_refs == 4'(INIT_REFRESHES))) else $error("wrong init refresh count");
  AST_REF_INTERVAL: assert property (@(posedge ref_clk) disable iff (!rst_n)
    q.init_done |-> (ast_since_ref_q <= AST_REF_MAX)) else $error("refresh interval exceeded");
  AST_POWERUP: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cmd_any && ast_first_q) |-> (ast_since_q >= 16'(POWERUP_CYCLES))) else $error("init before power-up delay");
  AST_RFC: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cmd_any && ast_last_q == CMD_REF) |-> (ast_since_q >= RFC_CYC)) else $error("refresh cycle time violated");
  AST_RP: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cmd_any && ast_last_q == CMD_PRE) |-> (ast_since_q >= RP_CYC)) else $error("precharge period violated");
  AST_RCD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_access and (ast_last_q == CMD_ACT)) |-> (ast_since_q >= RCD_CYC)) else $error("activate delay violated");
  AST_WR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_issue(CMD_PRE) |-> (ast_since_wr_q >= WR_CYC)) else $error("write recovery violated");
  AST_NO_AUTOPRE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_access |-> !q.addr[A10_BIT]) else $error("auto precharge used");
  AST_ONE_CS: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_issue(CMD_ACT) or s_access) |-> ($countones(~q.cs_n) == 1)) else $error("more than one chip selected");
  AST_ROW_CLOSE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (q.st == ST_IDLE && q.row_open && !q.have_req && q.wr_cnt == 16'h0000) |=> s_issue(CMD_PRE))
    else $error("idle row left open");
  AST_INIT_ORDER: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_access |-> q.init_done) else $error("access before initialization");
  AST_REF_PRIO: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (q.st == ST_IDLE && q.ref_due) |=> !s_access) else $error("access taken while refresh due");
  AST_REF_CLOSED: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_issue(CMD_REF) |-> !q.row_open) else $error("refresh with open row");
endmodule // sdtc_ctrl

// ### design/sdtc_fifo.sv
// small synchronous word fifo with valid/ready on both sides
`timescale 1ns/100ps
module sdtc_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 4
) (
  input wire logic    clk,
  input wire logic    rst_n,
  sdtc_stream_if.snk  push,
  sdtc_stream_if.src  pop
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } sdtc_fifo_s;

  sdtc_fifo_s q;
  sdtc_fifo_s n;
  logic       do_push;
  logic       do_pop;

  assign push.ready = (q.cnt != (AW + 1)'(DEPTH));
  assign pop.valid  = (q.cnt != '0);
  assign pop.data   = q.mem[q.rp];
  assign do_push    = push.valid && push.ready;
  assign do_pop     = pop.valid && pop.ready;

  always_comb begin
    n = q;
    if (do_push) begin
      n.mem[q.wp] = push.data;
      n.wp        = (q.wp == AW'(DEPTH - 1)) ? '0 : q.wp + AW'(1);
    end
    if (do_pop) begin
      n.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : q.rp + AW'(1);
    end
    case ({do_push, do_pop})
      2'h2:    n.cnt = q.cnt + (AW + 1)'(1);
      2'h1:    n.cnt = q.cnt - (AW + 1)'(1);
      default: n.cnt = q.cnt;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
endmodule // sdtc_fifo

// ### include/sdtc_pkg.sv
// constants, types and timing conversions for the sdram timing controller
package sdtc_pkg;

  localparam int CLK_PERIOD_PS = 4000;

  // times in their printed units
  localparam int T_POWERUP_US    = 100;
  localparam int T_RFC_NS        = 70;
  localparam int T_PRECHARGE_NS  = 20;
  localparam int T_RCD_NS        = 20;
  localparam int T_CLK_TO_OUT_NS = 17;
  localparam int T_WR_NS         = 14;
  localparam int T_REF_WINDOW_MS = 64;
  localparam int REF_COMMANDS    = 4096;

  // least times round up, never below one cycle
  function automatic int ns_to_cyc_up(input int t_ns);
    int c;
    c = (t_ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int         POWERUP_CYC = ns_to_cyc_up(T_POWERUP_US * 1000);
  localparam logic [15:0] RFC_CYC     = 16'(ns_to_cyc_up(T_RFC_NS));
  localparam logic [15:0] RP_CYC      = 16'(ns_to_cyc_up(T_PRECHARGE_NS));
  localparam logic [15:0] RCD_CYC     = 16'(ns_to_cyc_up(T_RCD_NS));
  localparam logic [15:0] WR_CYC      = 16'(ns_to_cyc_up(T_WR_NS));
  localparam int         AC_CYC      = ns_to_cyc_up(T_CLK_TO_OUT_NS);
  localparam logic [15:0] MRD_CYC     = 16'h0002;
  // longest time rounds down
  localparam logic [15:0] REF_INT_CYC = 16'((64'(T_REF_WINDOW_MS) * 64'd1000000000
                                        / 64'(REF_COMMANDS)) / 64'(CLK_PERIOD_PS));

  localparam int CAS_LATENCY_DEF  = 3;
  localparam int INIT_REFRESH_DEF = 2;

  // geometry, data width also sets mask width
  localparam int DQ_W    = 32;
  localparam int DQM_W   = DQ_W / 8;
  localparam int ROW_W   = 12;
  localparam int COL_W   = 8;
  localparam int BA_W    = 2;
  localparam int NCS     = 2;
  localparam int CS_W    = 1;
  localparam int ROW_LSB = COL_W;
  localparam int BA_LSB  = COL_W + ROW_W;
  localparam int CS_LSB  = COL_W + ROW_W + BA_W;
  localparam int HADDR_W = CS_LSB + CS_W;
  localparam int A10_BIT = 10;
  localparam int FIFO_DEPTH = 4;

  // {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_RD  = 3'h5;
  localparam logic [2:0] CMD_WR  = 3'h4;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_MRS = 3'h0;

  typedef enum logic [2:0] {
    ST_PWRUP    = 3'h0,
    ST_INIT_PRE = 3'h1,
    ST_INIT_REF = 3'h2,
    ST_INIT_MRS = 3'h3,
    ST_IDLE     = 3'h4,
    ST_WAIT     = 3'h5
  } sdtc_state_e;

endpackage

// ### include/sdtc_stream_if.sv
// valid/ready word stream between controller and its buffer
`timescale 1ns/100ps
interface sdtc_stream_if #(parameter int W = 32);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

// ### verif/sdram_timing_controller_tb.sv
// self-checking bench: host traffic against a behavioural sdram pair
`timescale 1ns/100ps
module sdram_timing_controller_tb import sdtc_pkg::*;;
  logic               ref_clk = 0, link_clk = 0, rst_n = 0, host_valid = 0, host_write = 0, host_rready = 0;
  logic [HADDR_W-1:0] host_addr = '0;
  logic [DQ_W-1:0]    host_wdata = '0, host_rdata, dq_drive, dq_sample, exp_d;
  logic [DQM_W-1:0]   host_be = '0, dqm;
  logic [ROW_W-1:0]   sd_addr, mode;
  logic [BA_W-1:0]    sd_ba;
  logic [NCS-1:0]     sd_cs_n;
  logic               host_ready, host_rvalid, init_done, sd_cke, ras_n, cas_n, we_n, dq_oe;
  logic [DQ_W-1:0]    tbm [int];
  logic [HADDR_W-1:0] keys [$];
  int                 err_count, total_checks, cyc, ref_gap, init_refs, bad, seed = 32'h87AC;
  always #2 ref_clk = ~ref_clk;
  always #62.5 link_clk = ~link_clk;
  sdtc_ctrl #(.POWERUP_CYCLES(50), .CAS_LATENCY(3), .INIT_REFRESHES(2)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .link_clk(link_clk), .host_valid(host_valid), .host_ready(host_ready), .host_write(host_write),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_be(host_be), .host_rvalid(host_rvalid),
    .host_rdata(host_rdata), .host_rready(host_rready), .init_done(init_done), .sd_cke(sd_cke),
    .sd_cs_n(sd_cs_n), .sd_ras_n(ras_n), .sd_cas_n(cas_n), .sd_we_n(we_n), .sd_ba(sd_ba), .sd_addr(sd_addr),
    .sd_dqm(dqm), .sd_dq_drive(dq_drive), .sd_dq_oe(dq_oe), .sd_dq_sample(dq_sample));
  sdtc_chip_model chips (.ref_clk(ref_clk), .sd_cs_n(sd_cs_n), .cmd({ras_n, cas_n, we_n}), .sd_ba(sd_ba),
    .sd_addr(sd_addr), .sd_dqm(dqm), .sd_dq_drive(dq_drive), .sd_dq_oe(dq_oe), .sd_dq_sample(dq_sample),
    .ref_gap(ref_gap), .init_refs(init_refs), .mode(mode), .bad(bad));
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask
  task host_op(input logic w, input logic [HADDR_W-1:0] a, input logic [DQ_W-1:0] d, input logic [DQM_W-1:0] be);
    int n;
    @(posedge link_clk);
    {host_valid, host_write, host_addr, host_wdata, host_be, host_rready} <= {1'b1, w, a, d, be, !w};
    n = 0;
    do begin @(posedge link_clk); n++; end while (host_ready !== 1'b1 && n < 400);
    host_valid <= 1'b0;
    if (w) begin
      if (!tbm.exists(a)) tbm[a] = '0;
      for (int b = 0; b < DQM_W; b++) if (be[b]) tbm[a][8*b+:8] = d[8*b+:8];
    end else begin
      // word may already stand at the edge that showed ready
      while (host_rvalid !== 1'b1 && n < 800) begin @(posedge link_clk); n++; end
      exp_d = tbm.exists(a) ? tbm[a] : '0;
      chk("host_rdata", exp_d, host_rdata);
    end
    if (n >= 400 + 400 * !w) begin
      err_count++;
      end_of_test;
    end
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      end_of_test;
    end
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    repeat (2) @(posedge link_clk);
    @(posedge ref_clk) rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      keys.push_back(HADDR_W'($random(seed)));
      host_op(1'b1, keys[i], $random(seed), i == 0 ? 4'h5 : DQM_W'($random(seed)));
    end
    host_op(1'b1, keys[0], $random(seed), 4'hA);
    chk("init refreshes", 32'h2, init_refs);
    chk("mode cas field", 32'h3, 32'(mode[6:4]));
    chk("init_done", 32'h1, 32'(init_done));
    chk("sd_cke", 32'h1, 32'(sd_cke));
    $display("test write done");
    foreach (keys[i]) host_op(1'b0, keys[i], '0, '0);
    $display("test read done");
    repeat (3 * int'(REF_INT_CYC) + 100) @(posedge ref_clk);
    chk("refresh gap", 32'(REF_INT_CYC), ref_gap);
    chk("pin faults", 32'h0, bad);
    chk("host_ready", 32'h1, 32'(host_ready));
    $display("test refresh done");
    end_of_test;
  end
endmodule // sdram_timing_controller_tb

// ### verif/sdtc_chip_model.sv
// behavioural pair of sdram chips on two selects
`timescale 1ns/100ps
module sdtc_chip_model import sdtc_pkg::*; (
  input wire logic             ref_clk,
  input wire logic [NCS-1:0]   sd_cs_n,
  input wire logic [2:0]       cmd,
  input wire logic [BA_W-1:0]  sd_ba,
  input wire logic [ROW_W-1:0] sd_addr,
  input wire logic [DQM_W-1:0] sd_dqm,
  input wire logic [DQ_W-1:0]  sd_dq_drive,
  input wire logic             sd_dq_oe,
  output logic [DQ_W-1:0]      sd_dq_sample,
  output int                   ref_gap,
  output int                   init_refs,
  output logic [ROW_W-1:0]     mode,
  output int                   bad
);
  logic [DQ_W-1:0]  mem [int];
  logic [ROW_W-1:0] rows [int];
  logic [DQ_W-1:0]  rd_val;
  int               rd_age, cnt, last_ref, k;
  // age at which the word must already stand before the capture edge
  localparam int    DATA_AGE = CAS_LATENCY_DEF + AC_CYC - 3;
  initial begin
    {sd_dq_sample, ref_gap, init_refs, mode, bad, rd_age, cnt, last_ref} = '0;
    rd_age = -1;
  end
  always @(posedge ref_clk) begin
    cnt <= cnt + 1;
    if (rd_age >= 0) rd_age <= (rd_age == 8) ? -1 : rd_age + 1;
    // word valid across capture edge only, else lines toggle
    if (rd_age == DATA_AGE) sd_dq_sample <= rd_val;
    else sd_dq_sample <= ~sd_dq_sample;
    if (sd_cs_n != 2'h3) begin
      if (cmd == CMD_ACT) rows[{sd_cs_n[0], sd_ba}] = sd_addr;
      if (cmd == CMD_RD || cmd == CMD_WR) begin
        if (^sd_cs_n !== 1'b1 || sd_addr[A10_BIT] !== 1'b0 || (cmd == CMD_WR && sd_dq_oe !== 1'b1)) begin
          bad <= bad + 1;
        end
        k = {sd_cs_n[0], sd_ba, rows[{sd_cs_n[0], sd_ba}], sd_addr[COL_W-1:0]};
        if (cmd == CMD_WR) begin
          if (!mem.exists(k)) mem[k] = '0;
          for (int b = 0; b < DQM_W; b++) if (!sd_dqm[b]) mem[k][8*b+:8] = sd_dq_drive[8*b+:8];
        end else begin
          rd_val <= mem.exists(k) ? mem[k] : '0;
          rd_age <= 0;
        end
      end
      if (cmd == CMD_REF) begin
        if (mode == '0) init_refs <= init_refs + 1;
        ref_gap <= cnt - last_ref;
        last_ref <= cnt;
      end
      if (cmd == CMD_MRS) mode <= sd_addr;
    end
  end
endmodule // sdtc_chip_model
